/* dv/converter_fault_protection_cfg_bench.sv */
// Self-checking bench for the converter fault-protection block
`timescale 1ns/1ps
module converter_fault_protection_cfg_bench;
  import fault_protect_pkg::*;
  logic        clk, rst, read, write, waitrequest, irq;
  logic [9:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic [1:0]  response, rs, openMode;
  logic        cycleStart, cycleEnd, openSense, clampOn, boostOverLevel;
  logic        adcLocked, tempAboveWakeup, secondStageEnable, boostEnable;
  logic [8:0]  boostOvervoltLevel;
  logic        overReq, lockReq, tempReq, clampReq;
  int          miscompares, n_compared, n;
  int          cyc = 0;
  // Open-fault cases: config, stimulus mode, fault expected
  localparam logic [47:0] OPEN_CFG = 48'h20272f404000;
  localparam logic [11:0] OPEN_MD  = 12'h564;
  localparam logic [5:0]  OPEN_EX  = 6'h2b;
  // Clamp cases with the clamp held on: config, fault expected
  localparam logic [23:0] CLAMP_CFG = 24'h000201;
  localparam logic [2:0]  CLAMP_EX  = 3'h5;

  converter_fault_protection_cfg #(.FAST_TICK(4), .CLAMP_TICK(4), .BOOST_TICK(4), .WIN1_SMP(200)) u_dut (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .cycleStart(cycleStart),
    .cycleEnd(cycleEnd), .openSense(openSense), .clampOn(clampOn),
    .boostOverLevel(boostOverLevel), .adcLocked(adcLocked), .tempAboveWakeup(tempAboveWakeup),
    .secondStageEnable(secondStageEnable), .boostEnable(boostEnable),
    .boostOvervoltLevel(boostOvervoltLevel), .irq(irq));
  stage_model u_stage (
    .clk(clk), .rst(rst), .runEn(secondStageEnable), .openMode(openMode), .overReq(overReq),
    .lockReq(lockReq), .tempReq(tempReq), .clampReq(clampReq), .cycleStart(cycleStart), .cycleEnd(cycleEnd),
    .openSense(openSense), .clampOn(clampOn), .boostOverLevel(boostOverLevel),
    .adcLocked(adcLocked), .tempAboveWakeup(tempAboveWakeup));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, wd};
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 100);
    chk(waitrequest, 1'b0);
    rd = readdata;
    rs = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Counts cycles until the chosen enable reaches the level
  task automatic waitEn(input logic boost, input logic lvl, input int lim);
    n = 0;
    while (n < lim && (boost ? boostEnable : secondStageEnable) !== lvl) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic doReset;
    rst <= 1'b1;
    lockReq <= 1'b0;
    tempReq <= 1'b0;
    openMode <= 2'h0;
    overReq <= 1'b0;
    clampReq <= 1'b0;
    wt(16);
    rst <= 1'b0;
  endtask
  task automatic t_regs;
    bus(1'b0, IDX_OPEN_CFG, 8'h00);
    chk(rd, 32'h00000020);
    bus(1'b0, IDX_RESTART_CFG, 8'h00);
    chk(rd, 32'h00000004);
    bus(1'b0, IDX_BOOST_CFG, 8'h00);
    chk(rd, 32'h00000000);
    bus(1'b1, IDX_CLAMP_CFG, 8'h5a);
    bus(1'b0, IDX_CLAMP_CFG, 8'h00);
    chk(rd, 32'h0000005a);
    bus(1'b0, 8'h10, 8'h00);
    chk(rd, 32'h00000000);
    chk({30'h0, rs}, 32'h00000002);
  endtask
  task automatic t_boot;
    lockReq <= 1'b1;
    wt(50);
    chk(boostEnable, 1'b0);
    tempReq <= 1'b1;
    waitEn(1'b1, 1'b1, 100);
    chk(boostEnable, 1'b1);
  endtask
  task automatic t_open;
    for (int i = 0; i < 6; i++) begin
      openMode <= 2'h0;
      bus(1'b1, IDX_RESTART_CFG, 8'h04);
      bus(1'b1, IDX_OPEN_CFG, OPEN_CFG[47-8*i -: 8]);
      // Let a fault left over from the previous case land before clearing
      wt(450);
      bus(1'b1, IDX_IRQ_STATUS, 8'h0f);
      openMode <= OPEN_MD[11-2*i -: 2];
      wt(1300);
      openMode <= 2'h0;
      bus(1'b0, IDX_IRQ_STATUS, 8'h00);
      chk(rd[1], OPEN_EX[5-i]);
    end
  endtask
  task automatic t_restart;
    bus(1'b1, IDX_OPEN_CFG, 8'h20);
    bus(1'b1, IDX_RESTART_CFG, 8'h0c);
    waitEn(1'b0, 1'b1, 100);
    bus(1'b1, IDX_IRQ_STATUS, 8'h0f);
    openMode <= 2'h1;
    waitEn(1'b0, 1'b0, 1000);
    chk(boostEnable, 1'b1);
    openMode <= 2'h0;
    waitEn(1'b0, 1'b1, 100);
    chk(n >= 10 && n <= 14, 1'b1);
    bus(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk(rd[0], 1'b1);
    bus(1'b1, IDX_RESTART_CFG, 8'h06);
    openMode <= 2'h1;
    waitEn(1'b0, 1'b0, 1000);
    openMode <= 2'h0;
    waitEn(1'b0, 1'b1, 7000);
    chk(n >= 6390 && n <= 6410, 1'b1);
  endtask
  task automatic t_boost;
    for (int lv = 0; lv < 16; lv++) begin
      bus(1'b1, IDX_BOOST_CFG, {3'h0, lv[3:0], 1'b1});
      wt(3);
      chk(boostOvervoltLevel, (227 + 2 * lv > 254) ? 254 : 227 + 2 * lv);
    end
    bus(1'b1, IDX_BOOST_CFG, 8'h01);
    bus(1'b1, IDX_IRQ_STATUS, 8'h0f);
    bus(1'b1, IDX_IRQ_MASK, 8'h08);
    overReq <= 1'b1;
    waitEn(1'b1, 1'b0, 3);
    chk(boostEnable, 1'b0);
    wt(2);
    chk(irq, 1'b1);
    overReq <= 1'b0;
    bus(1'b1, IDX_IRQ_MASK, 8'h00);
    wt(2);
    chk(irq, 1'b0);
    bus(1'b1, IDX_IRQ_MASK, 8'h08);
    wt(2);
    chk(irq, 1'b1);
    bus(1'b1, IDX_IRQ_STATUS, 8'h08);
    wt(2);
    chk(irq, 1'b0);
    // Trip level 1: filtered, so no immediate trip, then trip once integrated
    bus(1'b1, IDX_BOOST_CFG, 8'h21);
    overReq <= 1'b1;
    wt(8);
    chk(boostEnable, 1'b1);
    waitEn(1'b1, 1'b0, 100);
    chk(boostEnable, 1'b0);
    overReq <= 1'b0;
    waitEn(1'b1, 1'b1, 100);
    chk(boostEnable, 1'b1);
  endtask
  task automatic t_clamp;
    clampReq <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, IDX_CLAMP_CFG, CLAMP_CFG[23-8*i -: 8]);
      bus(1'b1, IDX_IRQ_STATUS, 8'h0f);
      wt(i == 2 ? 3300 : 1700);
      bus(1'b0, IDX_IRQ_STATUS, 8'h00);
      chk(rd[2], CLAMP_EX[2-i]);
    end
    clampReq <= 1'b0;
  endtask
  task automatic t_latch;
    bus(1'b1, IDX_OPEN_CFG, 8'h30);
    bus(1'b1, IDX_RESTART_CFG, 8'h05);
    openMode <= 2'h1;
    waitEn(1'b0, 1'b0, 1000);
    openMode <= 2'h0;
    wt(3);
    chk(boostEnable, 1'b0);
    wt(2000);
    chk({secondStageEnable, boostEnable}, 2'h0);
    bus(1'b0, IDX_STATE, 8'h00);
    chk(rd[12:9], {30'h0, ST_LATCHED});
    doReset;
    lockReq <= 1'b1;
    bus(1'b1, IDX_BOOST_CFG, 8'h01);
    waitEn(1'b1, 1'b1, 100);
    chk(boostEnable, 1'b1);
  endtask
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      miscompares++;
      print_verdict;
    end
  end
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    writedata = 32'h00000000;
    byteenable = 4'h1;
    openMode = 2'h0;
    overReq = 1'b0;
    lockReq = 1'b0;
    tempReq = 1'b0;
    clampReq = 1'b0;
    doReset;
    t_regs;
    t_boot;
    t_open;
    t_restart;
    t_boost;
    t_clamp;
    t_latch;
    print_verdict;
  end
endmodule

/* dv/stage_model.sv */
// Behavioural model of the power-stage sense comparators
`timescale 1ns/1ps
module stage_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Controls from the bench
  input  wire logic       runEn,
  input  wire logic [1:0] openMode,
  input  wire logic       overReq,
  input  wire logic       lockReq,
  input  wire logic       tempReq,
  input  wire logic       clampReq,
  // Sense outputs
  output logic            cycleStart,
  output logic            cycleEnd,
  output logic            openSense,
  output logic            clampOn,
  output logic            boostOverLevel,
  output logic            adcLocked,
  output logic            tempAboveWakeup
);
  logic [8:0] cnt;
  logic       odd;
  // Switching cycles of 400 clocks run only while the stage is enabled
  always_ff @(posedge clk) begin
    if (rst || !runEn) begin
      cnt <= 9'h000;
    end else begin
      cnt <= (cnt == 9'h18f) ? 9'h000 : cnt + 9'h001;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      odd <= 1'b0;
    end else if (cycleEnd) begin
      odd <= !odd;
    end
  end
  assign cycleStart = runEn && cnt == 9'h000;
  assign cycleEnd = runEn && cnt == 9'h18f;
  // Comparator trips late in the cycle; mode 2 only on every other cycle
  assign openSense = runEn && cnt >= 9'h12c && (openMode == 2'h1 || (openMode == 2'h2 && odd));
  assign clampOn = clampReq;
  assign boostOverLevel = overReq;
  assign adcLocked = lockReq;
  assign tempAboveWakeup = tempReq;
endmodule

/* rtl/converter_fault_protection_cfg.sv */
// Fault protection for the output-open and boost overvoltage faults; clamp overpower is only flagged in the interrupt status
`timescale 1ns/1ps
module converter_fault_protection_cfg
  import fault_protect_pkg::*;
#(
  parameter int FAST_TICK   = FAST_TICK_CYC,
  parameter int CLAMP_TICK  = CLAMP_TICK_CYC,
  parameter int BOOST_TICK  = BOOST_TICK_CYC,
  parameter int WIN1_SMP    = CLAMP_WIN1_SMP,
  parameter bit HIGH_LINE   = 1'b0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [1:0]       response,
  // Power stage sense
  input  wire logic        cycleStart,
  input  wire logic        cycleEnd,
  input  wire logic        openSense,
  input  wire logic        clampOn,
  input  wire logic        boostOverLevel,
  input  wire logic        adcLocked,
  input  wire logic        tempAboveWakeup,
  // Stage control
  output logic             secondStageEnable,
  output logic             boostEnable,
  output logic [8:0]       boostOvervoltLevel,
  // Interrupt
  output logic             irq
);
  import fault_protect_pkg::*;

  logic [7:0]   openCfg, restartCfg, clampCfg, boostCfg;
  logic [3:0]   irqStatus, irqMask, irqEvent;
  logic         acked;
  logic [7:0]   regIdx;
  logic         mapped;
  logic         fastTick, clampTick, boostTick;
  stage_state_e stageState;
  logic         boostOkStart, boostFault, clampFault, openFault;
  logic         secondFault, bothScope;
  logic [15:0]  cycleLen, prevCycleLen, blankCnt, blankLen;
  logic [2:0]   openRun, countLimit;
  logic         openSeen;
  logic [5:0]   restartLeft;
  logic [10:0]  slowDiv;
  logic         restartStep;
  logic [16:0]  clampWinCnt, clampOnCnt, clampLimit;
  logic [16:0]  winLen;
  logic [12:0]  integ;
  logic [12:0]  integTrip;
  logic [8:0]   rawLevel, capLevel;

  // Bus: one wait cycle, then answer
  assign regIdx      = address[9:2];
  assign mapped      = regIdx inside {IDX_OPEN_CFG, IDX_RESTART_CFG, IDX_CLAMP_CFG, IDX_BOOST_CFG,
                                      IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_STATE};
  assign waitrequest = (read || write) && !acked;

  always_ff @(posedge clk) begin
    if (rst) begin
      acked <= 1'b0;
    end else begin
      acked <= (read || write) && !acked;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      openCfg    <= RST_OPEN_CFG;
      restartCfg <= RST_RESTART_CFG;
      clampCfg   <= RST_CLAMP_CFG;
      boostCfg   <= RST_BOOST_CFG;
      irqMask    <= 4'h0;
    end else if (write && acked && byteenable[0]) begin
      unique case (regIdx)
        IDX_OPEN_CFG:    openCfg    <= writedata[7:0];
        IDX_RESTART_CFG: restartCfg <= writedata[7:0];
        IDX_CLAMP_CFG:   clampCfg   <= writedata[7:0];
        IDX_BOOST_CFG:   boostCfg   <= writedata[7:0];
        IDX_IRQ_MASK:    irqMask    <= writedata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readdata <= 32'h0;
      response <= 2'h0;
    end else if (read && !acked) begin
      response <= mapped ? 2'h0 : 2'h2;
      unique case (regIdx)
        IDX_OPEN_CFG:    readdata <= {24'h0, openCfg};
        IDX_RESTART_CFG: readdata <= {24'h0, restartCfg};
        IDX_CLAMP_CFG:   readdata <= {24'h0, clampCfg};
        IDX_BOOST_CFG:   readdata <= {24'h0, boostCfg};
        IDX_IRQ_STATUS:  readdata <= {28'h0, irqStatus};
        IDX_IRQ_MASK:    readdata <= {28'h0, irqMask};
        IDX_STATE:       readdata <= {19'h0, boostEnable, secondStageEnable, stageState, boostOvervoltLevel};
        default:         readdata <= 32'h0;
      endcase
    end
  end

  // Sticky events: set wins over write-one-to-clear
  assign irqEvent = {boostFault, clampFault, openFault, stageState == ST_RESTART && restartLeft == 6'h0};

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus <= 4'h0;
    end else begin
      irqStatus <= (irqStatus & ~((write && acked && byteenable[0] && regIdx == IDX_IRQ_STATUS)
                                  ? writedata[3:0] : 4'h0)) | irqEvent;
    end
  end

  assign irq = |(irqStatus & irqMask);

  // Rate enables
  tick_divider #(.DIV(FAST_TICK)) u_fast (.clk(clk), .rst(rst), .tick(fastTick));
  tick_divider #(.DIV(CLAMP_TICK)) u_clamp (.clk(clk), .rst(rst), .tick(clampTick));
  tick_divider #(.DIV(BOOST_TICK)) u_boost (.clk(clk), .rst(rst), .tick(boostTick));

  // Cycle length and blanking
  always_ff @(posedge clk) begin
    if (rst) begin
      cycleLen     <= 16'h0;
      prevCycleLen <= 16'h0;
    end else if (cycleStart) begin
      cycleLen     <= 16'h0;
      prevCycleLen <= cycleLen;
    end else if (cycleLen != 16'hffff) begin
      cycleLen <= cycleLen + 16'h1;
    end
  end

  always_comb begin
    if (openCfg[OPEN_KIND_BIT]) begin
      blankLen = (prevCycleLen > 16'(BLANK_OFFSET_CYC)) ? prevCycleLen - 16'(BLANK_OFFSET_CYC) : 16'h0;
    end else begin
      blankLen = 16'(BLANK_BASE_CYC) + 16'(openCfg[2:0]) * 16'(BLANK_STEP_CYC);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cycleStart) begin
      blankCnt <= 16'h0;
    end else if (blankCnt != 16'hffff) begin
      blankCnt <= blankCnt + 16'h1;
    end
  end

  // Consecutive open-condition counter
  assign countLimit = openCfg[7:OPEN_CNT_LSB];

  always_ff @(posedge clk) begin
    if (rst || cycleStart) begin
      openSeen <= 1'b0;
    end else if (openSense && blankCnt >= blankLen) begin
      openSeen <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || stageState != ST_RUN) begin
      openRun <= 3'h0;
    end else if (cycleEnd) begin
      openRun <= openSeen ? ((openRun == 3'h7) ? openRun : openRun + 3'h1) : 3'h0;
    end
  end

  assign openFault = stageState == ST_RUN && (countLimit == 3'h0 ||
                     (cycleEnd && openSeen && openRun + 3'h1 >= countLimit));
  assign secondFault = openFault;

  // Second stage state and restart timing
  assign restartStep = fastTick && (!restartCfg[SLOW_BIT] || slowDiv == 11'(SLOW_PER_FAST - 1));

  always_ff @(posedge clk) begin
    if (rst || stageState != ST_RESTART) begin
      slowDiv <= 11'h0;
    end else if (fastTick) begin
      slowDiv <= (slowDiv == 11'(SLOW_PER_FAST - 1)) ? 11'h0 : slowDiv + 11'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stageState  <= ST_RUN;
      restartLeft <= 6'h0;
      bothScope   <= 1'b0;
    end else begin
      unique case (stageState)
        ST_RUN: begin
          if (secondFault) begin
            bothScope   <= restartCfg[SCOPE_BIT];
            restartLeft <= restartCfg[7:RESTART_LSB];
            stageState  <= openCfg[OPEN_LAT_BIT] ? ST_LATCHED : ST_RESTART;
          end
        end
        ST_RESTART: begin
          if (restartLeft == 6'h0) begin
            stageState <= ST_RUN;
          end else if (restartStep) begin
            restartLeft <= restartLeft - 6'h1;
          end
        end
        ST_LATCHED: ;
        default: stageState <= ST_RUN;
      endcase
    end
  end

  // Clamp overpower window
  assign winLen     = clampCfg[CLAMP_WIN_BIT] ? 17'(2 * WIN1_SMP) : 17'(WIN1_SMP);
  assign clampLimit = clampCfg[CLAMP_WIN_BIT]
                    ? 17'(clampCfg[7:CLAMP_LIM_LSB]) * 17'(2 * CLAMP_STEP_SMP) + 17'(2 * CLAMP_BASE_SMP)
                    : 17'(clampCfg[7:CLAMP_LIM_LSB]) * 17'(CLAMP_STEP_SMP) + 17'(CLAMP_BASE_SMP);

  always_ff @(posedge clk) begin
    if (rst) begin
      clampWinCnt <= 17'h0;
      clampOnCnt  <= 17'h0;
    end else if (clampTick) begin
      if (clampWinCnt >= winLen - 17'h1) begin
        clampWinCnt <= 17'h0;
        clampOnCnt  <= 17'h0;
      end else begin
        clampWinCnt <= clampWinCnt + 17'h1;
        clampOnCnt  <= clampOnCnt + 17'(clampOn);
      end
    end
  end

  assign clampFault = clampTick && clampWinCnt >= winLen - 17'h1 &&
                      clampOnCnt + 17'(clampOn) > clampLimit;

  // Boost overvoltage level and leaky integrator
  assign rawLevel = 9'(boostCfg[4:BOOST_LVL_LSB]) * 9'(BOOST_STEP_V) +
                    (HIGH_LINE ? 9'(BOOST_HI_ON_V) : 9'(BOOST_LO_ON_V));
  assign capLevel = HIGH_LINE ? 9'(BOOST_HI_MAX_V) : 9'(BOOST_LO_MAX_V);

  always_ff @(posedge clk) begin
    if (rst) begin
      boostOvervoltLevel <= 9'h0;
    end else begin
      boostOvervoltLevel <= (rawLevel > capLevel) ? capLevel : rawLevel;
    end
  end

  assign integTrip = 13'(boostCfg[7:BOOST_TRIP_LSB]) << INTEG_FRAC;

  always_ff @(posedge clk) begin
    if (rst) begin
      integ <= 13'h0;
    end else if (boostTick) begin
      integ <= integ - (integ >> INTEG_SHIFT) +
               (boostOverLevel ? 13'(INTEG_INPUT) : 13'h0);
    end
  end

  assign boostFault = (boostCfg[7:BOOST_TRIP_LSB] == 3'h0) ? boostOverLevel
                    : integ > integTrip;

  // Boost start-up and stage enables
  always_ff @(posedge clk) begin
    if (rst) begin
      boostOkStart <= 1'b0;
    end else if (adcLocked && (boostCfg[BOOST_ON_BIT] || tempAboveWakeup)) begin
      boostOkStart <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      secondStageEnable <= 1'b0;
      boostEnable       <= 1'b0;
    end else begin
      secondStageEnable <= stageState == ST_RUN && !secondFault;
      boostEnable       <= boostOkStart && !boostFault && !(stageState != ST_RUN && bothScope);
    end
  end

  a_latched_holds: assert property (@(posedge clk) disable iff (rst)
    stageState == ST_LATCHED |=> stageState == ST_LATCHED) else $error("latched fault left");
  a_force_open: assert property (@(posedge clk) disable iff (rst)
    stageState == ST_RUN && countLimit == 3'h0 |=> !secondStageEnable) else $error("forced fault missed");
  a_latch_sel: assert property (@(posedge clk) disable iff (rst)
    stageState == ST_RUN && openFault && !openCfg[OPEN_LAT_BIT] |=> stageState == ST_RESTART)
    else $error("unlatched fault wrong state");
  a_scope_only: assert property (@(posedge clk) disable iff (rst)
    stageState == ST_RESTART && !bothScope && boostOkStart && !boostFault |=> boostEnable)
    else $error("boost stopped on second stage fault");
  a_scope_both: assert property (@(posedge clk) disable iff (rst)
    stageState != ST_RUN && bothScope |=> !boostEnable) else $error("boost kept on");
  a_level_cap: assert property (@(posedge clk) disable iff (rst)
    ##1 boostOvervoltLevel <= capLevel) else $error("boost level over cap");
  a_bypass_trip: assert property (@(posedge clk) disable iff (rst)
    boostCfg[7:5] == 3'h0 && boostOverLevel |=> !boostEnable) else $error("bypass did not trip");
  a_boost_start: assert property (@(posedge clk) disable iff (rst)
    !adcLocked && !boostOkStart |=> !boostOkStart) else $error("boost started early");
  a_run_clear: assert property (@(posedge clk) disable iff (rst)
    stageState == ST_RUN && cycleEnd && !openSeen |=> openRun == 3'h0) else $error("run not cleared");
  a_restart_count: assert property (@(posedge clk) disable iff (rst)
    stageState == ST_RESTART && restartStep && restartLeft != 6'h0 |=> restartLeft == $past(restartLeft) - 6'h1)
    else $error("restart count stuck");

  c_open_fault: cover property (@(posedge clk) disable iff (rst) openFault);
  c_restart_done: cover property (@(posedge clk) disable iff (rst)
    stageState == ST_RESTART ##1 stageState == ST_RUN);
  c_clamp_fault: cover property (@(posedge clk) disable iff (rst) clampFault);
  c_boost_fault: cover property (@(posedge clk) disable iff (rst) boostFault && integ != 13'h0);
endmodule

/* rtl/fault_protect_pkg.sv */
// Constants for the converter fault-protection block
package fault_protect_pkg;
  localparam int CLK_MHZ = 250;
  // Register indices (byte address = 4 * index)
  localparam logic [7:0] IDX_OPEN_CFG    = 8'h52;
  localparam logic [7:0] IDX_RESTART_CFG = 8'h53;
  localparam logic [7:0] IDX_CLAMP_CFG   = 8'h54;
  localparam logic [7:0] IDX_BOOST_CFG   = 8'h55;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h60;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h61;
  localparam logic [7:0] IDX_STATE       = 8'h62;
  // Reset values
  localparam logic [7:0] RST_OPEN_CFG    = 8'h20;
  localparam logic [7:0] RST_RESTART_CFG = 8'h04;
  localparam logic [7:0] RST_CLAMP_CFG   = 8'h00;
  localparam logic [7:0] RST_BOOST_CFG   = 8'h00;
  // Field positions
  localparam int OPEN_CNT_LSB   = 5;
  localparam int OPEN_LAT_BIT   = 4;
  localparam int OPEN_KIND_BIT  = 3;
  localparam int RESTART_LSB    = 2;
  localparam int SLOW_BIT       = 1;
  localparam int SCOPE_BIT      = 0;
  localparam int CLAMP_LIM_LSB  = 1;
  localparam int CLAMP_WIN_BIT  = 0;
  localparam int BOOST_TRIP_LSB = 5;
  localparam int BOOST_LVL_LSB  = 1;
  localparam int BOOST_ON_BIT   = 0;
  // Timing, in ns unless named otherwise
  localparam int BLANK_BASE_NS   = 1000;
  localparam int BLANK_STEP_NS   = 500;
  localparam int BLANK_OFFSET_NS = 500;
  localparam int FAST_RESTART_NS = 25600;
  localparam int SLOW_RESTART_US = 40960;
  localparam int CLAMP_SAMPLE_NS = 20000;
  localparam int BOOST_SAMPLE_NS = 80000;
  localparam int BLANK_BASE_CYC   = BLANK_BASE_NS / 4;
  localparam int BLANK_STEP_CYC   = BLANK_STEP_NS / 4;
  localparam int BLANK_OFFSET_CYC = BLANK_OFFSET_NS / 4;
  localparam int FAST_TICK_CYC    = FAST_RESTART_NS * CLK_MHZ / 1000;
  localparam int SLOW_PER_FAST    = SLOW_RESTART_US * 1000 / FAST_RESTART_NS;
  localparam int CLAMP_TICK_CYC   = CLAMP_SAMPLE_NS * CLK_MHZ / 1000;
  localparam int BOOST_TICK_CYC   = BOOST_SAMPLE_NS * CLK_MHZ / 1000;
  // Clamp limits in 20 us samples: 5.12 ms = 256, 2.56 ms = 128
  localparam int CLAMP_STEP_SMP   = 256;
  localparam int CLAMP_BASE_SMP   = 128;
  localparam int CLAMP_WIN1_SMP   = 50000;
  // Boost levels in volts
  localparam int BOOST_LO_ON_V    = 227;
  localparam int BOOST_HI_ON_V    = 432;
  localparam int BOOST_LO_MAX_V   = 254;
  localparam int BOOST_HI_MAX_V   = 508;
  localparam int BOOST_STEP_V     = 2;
  localparam int INTEG_INPUT      = 8;
  localparam int INTEG_SHIFT      = 6;
  // Integrator output is scaled by 64; trip level n means n * 64
  localparam int INTEG_FRAC       = 6;
  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_RESTART = 2'b01,
    ST_LATCHED = 2'b10
  } stage_state_e;
endpackage

/* rtl/tick_divider.sv */
// Divider that emits a one-cycle enable every DIV clocks
`timescale 1ns/1ps
module tick_divider #(
  parameter int DIV = 5000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Enable out
  output logic      tick
);
  logic [$clog2(DIV+1)-1:0] count;

  always_ff @(posedge clk) begin
    if (rst || tick) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign tick = (count == ($clog2(DIV+1))'(DIV - 1));
endmodule
